/* File: hwe_wake_aggregator.sv */
`timescale 1ns/10ps
`default_nettype none
module hwe_wake_aggregator
    import hwe_pkg::*;
#(
    parameter int GPIO_PINS = 8,
    parameter int MBX_BITS  = 16,
    parameter int FW_BITS   = 8
) (
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       arst_n,
    // host register port
    input  wire logic [7:0]                 reg_addr,
    input  wire logic                       reg_wr,
    input  wire logic [7:0]                 reg_wdata,
    input  wire logic                       reg_rd,
    output logic      [7:0]                 reg_rdata,
    // peripheral wake sources
    input  wire logic                       ring_pin_port1_n,
    input  wire logic                       ring_pin_port2_n,
    input  wire logic                       keyboard_data_pin,
    input  wire logic                       pointer_data_pin,
    input  wire logic                       special_key_wake,
    // system wake sources
    input  wire logic                       sys_mgmt_irq_pin_n,
    input  wire logic                       watchdog_timeout_flag,
    input  wire logic [MBX_BITS-1:0]        mailbox_src,
    input  wire logic [MBX_BITS-1:0]        mailbox_irq_en,
    input  wire logic [FW_BITS-1:0]         firmware_evt_sts,
    input  wire logic [FW_BITS-1:0]         firmware_evt_en,
    input  wire logic                       intrusion_flag,
    // battery monitor
    input  wire logic                       standby_supply_valid,
    input  wire logic                       main_reset_release,
    input  wire logic                       lost_battery_flag,
    input  wire logic                       battery_under_threshold,
    // gpio wake sources
    input  wire logic [GPIO_PINS-1:0]       gpio_pin,
    input  wire logic [GPIO_PINS*DET_W-1:0] gpio_det_mode,
    // open-drain wake request pin
    output logic                            wake_request_pin_out,
    output logic                            wake_request_pin_oe
);
    // ========================================================
    // state
    logic       flag_reg;
    logic       flag_next;
    logic [7:0] out_en_reg;
    logic [7:0] out_en_next;
    logic [7:0] sts_per_reg;
    logic [7:0] sts_per_next;
    logic [7:0] sts_sys_reg;
    logic [7:0] sts_sys_next;
    logic [7:0] sts_gpio_reg;
    logic [7:0] sts_gpio_next;
    logic [7:0] en_per_reg;
    logic [7:0] en_per_next;
    logic [7:0] en_sys_reg;
    logic [7:0] en_sys_next;
    logic [7:0] en_gpio_reg;
    logic [7:0] en_gpio_next;
    logic       oe_reg;
    logic       oe_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // ========================================================
    // event sources, write strobes and wake summary
    logic [3:0]           fall_evt;
    logic [GPIO_PINS-1:0] gpio_evt;
    logic [7:0]           per_evt;
    logic [7:0]           sys_set;
    logic [7:0]           sys_lvl;
    logic [7:0]           gpio_set;
    logic                 any_wake;
    logic [7:0]           wr_per;
    logic [7:0]           wr_sys;
    logic [7:0]           wr_gpio;
    logic                 wr_flag;

    // ring, keyboard and pointer lines go through a fixed falling-edge detector, with nothing for the host to arm
    hwe_fall_detect #(
        .WIDTH (4)
    ) u_fall (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .line_in    ({pointer_data_pin, keyboard_data_pin,
                      ring_pin_port1_n, ring_pin_port2_n}),
        .fall_pulse (fall_evt)
    );

    hwe_gpio_wake #(
        .PINS (GPIO_PINS)
    ) u_gpio (
        .core_clk      (core_clk),
        .arst_n        (arst_n),
        .gpio_pin      (gpio_pin),
        .gpio_det_mode (gpio_det_mode),
        .gpio_event    (gpio_evt)
    );

    // ========================================================
    // event and write decode
    always_comb begin
        per_evt                = 8'h00;
        per_evt[BIT_RING2]     = fall_evt[0];
        per_evt[BIT_RING1]     = fall_evt[1];
        per_evt[BIT_KEYBOARD]  = fall_evt[2];
        per_evt[BIT_POINTER]   = fall_evt[3];
        per_evt[BIT_SPECIAL]   = special_key_wake;

        sys_set                = 8'h00;
        sys_set[BIT_SMI]       = ~sys_mgmt_irq_pin_n;
        sys_set[BIT_WATCHDOG]  = watchdog_timeout_flag;
        sys_set[BIT_LOW_BAT]   = main_reset_release & battery_under_threshold;

        sys_lvl                = 8'h00;
        sys_lvl[BIT_MBX_WRITE] = mailbox_src[0];
        sys_lvl[BIT_MBX_ANY]   = |(mailbox_src & mailbox_irq_en);
        sys_lvl[BIT_FIRMWARE]  = |(firmware_evt_sts & firmware_evt_en);
        sys_lvl[BIT_INTRUSION] = intrusion_flag;

        gpio_set               = 8'h00;
        gpio_set[GPIO_PINS-1:0] = gpio_evt;

        wr_flag = reg_wr && (reg_addr == OFS_SUMMARY) && reg_wdata[BIT_SUMMARY];
        wr_per  = (reg_wr && reg_addr == OFS_STS_PERIPH) ? reg_wdata : 8'h00;
        wr_sys  = (reg_wr && reg_addr == OFS_STS_SYSTEM) ? reg_wdata : 8'h00;
        wr_gpio = (reg_wr && reg_addr == OFS_STS_GPIO)   ? reg_wdata : 8'h00;

        any_wake = |(sts_per_reg & en_per_reg) ||
                   |(sts_sys_reg & en_sys_reg) ||
                   |(sts_gpio_reg & en_gpio_reg);
    end

    // ========================================================
    // status registers: an event in the clearing cycle survives
    always_comb begin
        sts_per_next  = ((sts_per_reg & ~wr_per) | per_evt) & MASK_PERIPH;
        sts_gpio_next = ((sts_gpio_reg & ~wr_gpio) | gpio_set) & MASK_GPIO;
        sts_sys_next  = (((sts_sys_reg & ~wr_sys) | sys_set) & W1C_SYSTEM)
                        | (sys_lvl & ~W1C_SYSTEM & MASK_SYSTEM);
        if (standby_supply_valid) begin
            sts_sys_next[BIT_LOW_BAT] = lost_battery_flag;
        end
    end

    // ========================================================
    // summary flag and pin
    always_comb begin
        flag_next = flag_reg;
        if (wr_flag) begin
            flag_next = 1'b0;
        end
        if (any_wake) begin
            flag_next = 1'b1;
        end
        oe_next = flag_reg & out_en_reg[BIT_OUT_EN];
    end

    // ========================================================
    // enable registers
    always_comb begin
        out_en_next  = out_en_reg;
        en_per_next  = en_per_reg;
        en_sys_next  = en_sys_reg;
        en_gpio_next = en_gpio_reg;
        if (reg_wr) begin
            case (reg_addr)
                OFS_OUT_EN:    out_en_next  = reg_wdata & MASK_OUT_EN;
                OFS_EN_PERIPH: en_per_next  = reg_wdata & MASK_PERIPH;
                OFS_EN_SYSTEM: en_sys_next  = reg_wdata & MASK_SYSTEM;
                OFS_EN_GPIO:   en_gpio_next = reg_wdata & MASK_GPIO;
                default: ;
            endcase
        end
        // enable is not battery backed, so it starts off with standby
        if (standby_supply_valid) begin
            en_sys_next[BIT_LOW_BAT] = 1'b0;
        end
    end

    // ========================================================
    // read path
    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd) begin
            case (reg_addr)
                OFS_SUMMARY:    rdata_next = {7'h00, flag_reg};
                OFS_OUT_EN:     rdata_next = out_en_reg;
                OFS_STS_PERIPH: rdata_next = sts_per_reg;
                OFS_STS_SYSTEM: rdata_next = sts_sys_reg;
                OFS_STS_GPIO:   rdata_next = sts_gpio_reg;
                OFS_EN_PERIPH:  rdata_next = en_per_reg;
                OFS_EN_SYSTEM:  rdata_next = en_sys_reg;
                OFS_EN_GPIO:    rdata_next = en_gpio_reg;
                default:        rdata_next = 8'h00;
            endcase
        end
    end

    // ========================================================
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_reg     <= 1'b0;
            out_en_reg   <= RST_REG;
            sts_per_reg  <= RST_REG;
            sts_sys_reg  <= RST_REG;
            sts_gpio_reg <= RST_REG;
            en_per_reg   <= RST_REG;
            en_sys_reg   <= RST_REG;
            en_gpio_reg  <= RST_REG;
            oe_reg       <= 1'b0;
            rdata_reg    <= RST_REG;
        end else begin
            flag_reg     <= flag_next;
            out_en_reg   <= out_en_next;
            sts_per_reg  <= sts_per_next;
            sts_sys_reg  <= sts_sys_next;
            sts_gpio_reg <= sts_gpio_next;
            en_per_reg   <= en_per_next;
            en_sys_reg   <= en_sys_next;
            en_gpio_reg  <= en_gpio_next;
            oe_reg       <= oe_next;
            rdata_reg    <= rdata_next;
        end
    end

    // open drain: only ever pulls low
    assign wake_request_pin_out = 1'b0;
    assign wake_request_pin_oe  = oe_reg;
    assign reg_rdata            = rdata_reg;

    // ========================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence s_ring2_fall;
        $fell(ring_pin_port2_n) ##2 1'b1;
    endsequence
    sequence s_kbd_fall;
        $fell(keyboard_data_pin) ##2 1'b1;
    endsequence

    a_summary_set: assert property (any_wake |=> flag_reg)
        else $error("summary flag not set");
    a_summary_clear: assert property (wr_flag && !any_wake |=> !flag_reg)
        else $error("summary flag not cleared");
    a_pin_assert: assert property (flag_reg && out_en_reg[0] |=> wake_request_pin_oe)
        else $error("wake pin not driven");
    a_pin_quiet: assert property (!(flag_reg && out_en_reg[0]) |=> !wake_request_pin_oe)
        else $error("wake pin driven without cause");
    a_out_en_bits: assert property (out_en_reg[7:1] == 7'h00)
        else $error("reserved enable bits set");
    a_ring_edge: assert property (s_ring2_fall |-> sts_per_reg[BIT_RING2])
        else $error("ring wake missed");
    a_kbd_edge: assert property (s_kbd_fall |-> sts_per_reg[BIT_KEYBOARD])
        else $error("keyboard wake missed");
    a_status_hold: assert property (sts_per_reg[BIT_SPECIAL] && wr_per[BIT_SPECIAL] == 1'b0
        |=> sts_per_reg[BIT_SPECIAL]) else $error("status bit lost");
    a_w1c_gpio: assert property (wr_gpio[0] && !gpio_evt[0] |=> !sts_gpio_reg[0])
        else $error("gpio status not cleared");
    a_smi_mirror: assert property (!sys_mgmt_irq_pin_n |=> sts_sys_reg[BIT_SMI])
        else $error("smi status not set");
    a_intrusion: assert property (##1 sts_sys_reg[BIT_INTRUSION] == $past(intrusion_flag))
        else $error("intrusion mirror wrong");
    a_battery_load: assert property (standby_supply_valid
        |=> sts_sys_reg[BIT_LOW_BAT] == $past(lost_battery_flag) && !en_sys_reg[BIT_LOW_BAT])
        else $error("battery load wrong");
    a_reserved_zero: assert property ((sts_per_reg & ~MASK_PERIPH) == 8'h00
        && sts_sys_reg[7] == 1'b0) else $error("reserved status bit set");
endmodule : hwe_wake_aggregator
`default_nettype wire

/* File: hwe_pkg.sv */
`default_nettype none
// ============================================================
// shared constants of the host wake event aggregator
package hwe_pkg;
    // ========================================================
    // register offsets
    localparam logic [7:0] OFS_SUMMARY    = 8'h00;
    localparam logic [7:0] OFS_OUT_EN     = 8'h01;
    localparam logic [7:0] OFS_STS_PERIPH = 8'h02;
    localparam logic [7:0] OFS_STS_SYSTEM = 8'h03;
    localparam logic [7:0] OFS_STS_GPIO   = 8'h04;
    localparam logic [7:0] OFS_EN_PERIPH  = 8'h05;
    localparam logic [7:0] OFS_EN_SYSTEM  = 8'h06;
    localparam logic [7:0] OFS_EN_GPIO    = 8'h07;

    // ========================================================
    // implemented bits per register, reserved bits read zero
    localparam logic [7:0] MASK_SUMMARY   = 8'h01;
    localparam logic [7:0] MASK_OUT_EN    = 8'h01;
    localparam logic [7:0] MASK_PERIPH    = 8'h3E;
    localparam logic [7:0] MASK_SYSTEM    = 8'h7F;
    localparam logic [7:0] MASK_GPIO      = 8'hFF;
    localparam logic [7:0] W1C_SYSTEM     = 8'h23;

    // ========================================================
    // reset values
    localparam logic [7:0] RST_REG        = 8'h00;
    localparam logic [3:0] RST_PIN_PREV   = 4'hF;

    // ========================================================
    // field positions
    localparam int BIT_SUMMARY   = 0;
    localparam int BIT_OUT_EN    = 0;
    localparam int BIT_RING2     = 1;
    localparam int BIT_RING1     = 2;
    localparam int BIT_KEYBOARD  = 3;
    localparam int BIT_POINTER   = 4;
    localparam int BIT_SPECIAL   = 5;
    localparam int BIT_SMI       = 0;
    localparam int BIT_WATCHDOG  = 1;
    localparam int BIT_MBX_WRITE = 2;
    localparam int BIT_MBX_ANY   = 3;
    localparam int BIT_FIRMWARE  = 4;
    localparam int BIT_LOW_BAT   = 5;
    localparam int BIT_INTRUSION = 6;

    // ========================================================
    // gpio interrupt detection field
    localparam int          DET_W       = 3;
    localparam logic [2:0]  DET_LOW     = 3'h0;
    localparam logic [2:0]  DET_HIGH    = 3'h1;
    localparam logic [2:0]  DET_RISE    = 3'h2;
    localparam logic [2:0]  DET_FALL    = 3'h3;
    localparam logic [2:0]  DET_BOTH    = 3'h4;
    localparam logic [2:0]  DET_NONE    = 3'h7;
endpackage : hwe_pkg
`default_nettype wire

/* File: hwe_fall_detect.sv */
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// one-cycle pulse on each falling edge of an active-low line
module hwe_fall_detect
    import hwe_pkg::*;
#(
    parameter int WIDTH = 4
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             arst_n,
    // lines and pulses
    input  wire logic [WIDTH-1:0] line_in,
    output logic      [WIDTH-1:0] fall_pulse
);
    logic [WIDTH-1:0] prev_reg;
    logic [WIDTH-1:0] prev_next;
    logic [WIDTH-1:0] fall_reg;
    logic [WIDTH-1:0] fall_next;

    // ========================================================
    // idle lines sit high, so no edge is seen out of reset
    always_comb begin
        prev_next = line_in;
        fall_next = prev_reg & ~line_in;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_reg <= {WIDTH{1'b1}};
            fall_reg <= '0;
        end else begin
            prev_reg <= prev_next;
            fall_reg <= fall_next;
        end
    end

    assign fall_pulse = fall_reg;

    a_fall_pulse: assert property (@(posedge core_clk) disable iff (!arst_n)
        $fell(line_in[0]) |=> fall_pulse[0]) else $error("fall not detected");
endmodule : hwe_fall_detect
`default_nettype wire

/* File: hwe_gpio_wake.sv */
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// per-pin edge wake detection steered by the detection field
module hwe_gpio_wake
    import hwe_pkg::*;
#(
    parameter int PINS = 8
) (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  arst_n,
    // gpio pins and their detection fields
    input  wire logic [PINS-1:0]       gpio_pin,
    input  wire logic [PINS*DET_W-1:0] gpio_det_mode,
    // wake pulses
    output logic      [PINS-1:0]       gpio_event
);
    logic [PINS-1:0]       pin_reg;
    logic [PINS*DET_W-1:0] mode_reg;
    logic [PINS-1:0]       evt_reg;
    logic [PINS-1:0]       evt_next;

    // ========================================================
    function automatic logic is_edge(input logic [2:0] m);
        is_edge = (m == DET_RISE) || (m == DET_FALL) || (m == DET_BOTH);
    endfunction : is_edge

    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            logic [2:0] mode;
            logic [2:0] mode_old;
            logic       rise;
            logic       fall;
            assign mode     = gpio_det_mode[g*DET_W +: DET_W];
            assign mode_old = mode_reg[g*DET_W +: DET_W];
            assign rise     = ~pin_reg[g] & gpio_pin[g];
            assign fall     = pin_reg[g] & ~gpio_pin[g];
            // levels never wake; arming an edge mode on a high pin does
            always_comb begin
                evt_next[g] = ((mode == DET_RISE) && rise) ||
                              ((mode == DET_FALL) && fall) ||
                              ((mode == DET_BOTH) && (rise || fall)) ||
                              (!is_edge(mode_old) && is_edge(mode) && gpio_pin[g]);
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_reg  <= '0;
            mode_reg <= {PINS{DET_NONE}};
            evt_reg  <= '0;
        end else begin
            pin_reg  <= gpio_pin;
            mode_reg <= gpio_det_mode;
            evt_reg  <= evt_next;
        end
    end

    assign gpio_event = evt_reg;

    a_level_quiet: assert property (@(posedge core_clk) disable iff (!arst_n)
        (gpio_det_mode[2:0] == DET_LOW || gpio_det_mode[2:0] == DET_HIGH)
        |=> !gpio_event[0]) else $error("level mode produced a wake");
    a_arm_high: assert property (@(posedge core_clk) disable iff (!arst_n)
        (mode_reg[2:0] == DET_NONE && gpio_det_mode[2:0] == DET_RISE && gpio_pin[0])
        |=> gpio_event[0]) else $error("arming on high pin missed");
endmodule : hwe_gpio_wake
`default_nettype wire

/* File: hwe_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ====================
// host side of the register port
module hwe_host_model
    import hwe_pkg::*;
(
    // clock
    input  wire logic       core_clk,
    // register port
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    // strobe stands one whole cycle so exactly one edge takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge core_clk);
        reg_wr    = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge core_clk);
        reg_rd   = 1'b0;
        d        = reg_rdata;
    endtask : rd
endmodule : hwe_host_model
`default_nettype wire

/* File: hwe_wake_aggregator_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module hwe_wake_aggregator_tb
    import hwe_pkg::*;
;
    logic        core_clk = 0, arst_n = 0, reg_wr, reg_rd, oe, od;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv, gpio = 0;
    logic [3:0]  lines = 4'hF;
    logic        spk = 0, smi_n = 1, wdog = 0, intr = 0;
    logic        sby = 0, mrel = 0, lost = 0, under = 0;
    logic [15:0] msrc = 0, men = 0;
    logic [7:0]  fsts = 0, fen = 0;
    logic [23:0] det = {8{DET_NONE}};
    int          miscompares = 0, check_count = 0;
    always #5 core_clk = ~core_clk;
    hwe_wake_aggregator uut (.core_clk(core_clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ring_pin_port2_n(lines[0]), .ring_pin_port1_n(lines[1]),
        .keyboard_data_pin(lines[2]), .pointer_data_pin(lines[3]), .special_key_wake(spk),
        .sys_mgmt_irq_pin_n(smi_n), .watchdog_timeout_flag(wdog), .mailbox_src(msrc),
        .mailbox_irq_en(men), .firmware_evt_sts(fsts), .firmware_evt_en(fen),
        .intrusion_flag(intr), .standby_supply_valid(sby), .main_reset_release(mrel),
        .lost_battery_flag(lost), .battery_under_threshold(under), .gpio_pin(gpio),
        .gpio_det_mode(det), .wake_request_pin_out(od), .wake_request_pin_oe(oe));
    hwe_host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    // ====================
    // checking helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, rv);
        chk(rv, exp);
    endtask : rchk
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask : idle
    task automatic tally_and_finish;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    // ====================
    // scenarios
    task automatic t_periph;
        host.wr(OFS_EN_PERIPH, 8'hFF);
        rchk(OFS_EN_PERIPH, MASK_PERIPH);
        host.wr(OFS_OUT_EN, 8'hFF);
        rchk(OFS_OUT_EN, 8'h01);
        for (int i = 0; i < 4; i++) begin
            lines[i] = 1'b0;
            idle(3);
            rchk(OFS_STS_PERIPH, 8'h02 << i);
            rchk(OFS_SUMMARY, 8'h01);
            chk({7'h0, oe}, 8'h01);
            host.wr(OFS_STS_PERIPH, 8'h00);
            rchk(OFS_STS_PERIPH, 8'h02 << i);
            host.wr(OFS_STS_PERIPH, 8'hFF);
            rchk(OFS_STS_PERIPH, 8'h00);
            host.wr(OFS_SUMMARY, 8'h00);
            rchk(OFS_SUMMARY, 8'h01);
            host.wr(OFS_SUMMARY, 8'h01);
            rchk(OFS_SUMMARY, 8'h00);
            idle(1);
            chk({7'h0, oe}, 8'h00);
            lines[i] = 1'b1;
        end
        spk = 1'b1;
        idle(1);
        spk = 1'b0;
        idle(2);
        rchk(OFS_STS_PERIPH, 8'h20);
        host.wr(OFS_STS_PERIPH, 8'hFF);
    endtask : t_periph
    task automatic t_system;
        host.wr(OFS_EN_SYSTEM, 8'hFF);
        rchk(OFS_EN_SYSTEM, MASK_SYSTEM);
        smi_n = 1'b0;
        wdog  = 1'b1;
        msrc  = 16'h0001;
        fsts  = 8'h01;
        intr  = 1'b1;
        idle(1);
        smi_n = 1'b1;
        wdog  = 1'b0;
        idle(2);
        rchk(OFS_STS_SYSTEM, 8'h47);
        host.wr(OFS_STS_SYSTEM, 8'hFF);
        rchk(OFS_STS_SYSTEM, 8'h44);
        msrc = 16'h8000;
        men  = 16'h8000;
        fen  = 8'h01;
        intr = 1'b0;
        idle(2);
        rchk(OFS_STS_SYSTEM, 8'h18);
        msrc = 16'h0000;
        fsts = 8'h00;
        lost = 1'b1;
        sby  = 1'b1;
        idle(1);
        sby  = 1'b0;
        idle(1);
        rchk(OFS_STS_SYSTEM, 8'h20);
        rchk(OFS_EN_SYSTEM, 8'h5F);
        host.wr(OFS_STS_SYSTEM, 8'hFF);
        rchk(OFS_STS_SYSTEM, 8'h00);
        under = 1'b1;
        mrel  = 1'b1;
        idle(1);
        mrel  = 1'b0;
        idle(1);
        rchk(OFS_STS_SYSTEM, 8'h20);
        host.wr(OFS_STS_SYSTEM, 8'hFF);
        host.wr(OFS_SUMMARY, 8'h01);
    endtask : t_system
    task automatic t_gpio;
        host.wr(OFS_EN_GPIO, 8'hFF);
        gpio      = 8'h07;
        det[2:0]  = DET_FALL;
        det[5:3]  = DET_LOW;
        idle(3);
        host.wr(OFS_STS_GPIO, 8'hFF);
        rchk(OFS_STS_GPIO, 8'h00);
        gpio = 8'h04;
        idle(3);
        rchk(OFS_STS_GPIO, 8'h01);
        det[8:6] = DET_RISE;
        idle(3);
        rchk(OFS_STS_GPIO, 8'h05);
        det[11:9]  = DET_BOTH;
        det[14:12] = DET_HIGH;
        idle(3);
        gpio = 8'h1C;
        idle(3);
        rchk(OFS_STS_GPIO, 8'h0D);
        host.wr(OFS_STS_GPIO, 8'hFF);
    endtask : t_gpio
    // ====================
    // main sequence and hang guard
    initial begin
        repeat (20) @(negedge core_clk);
        arst_n = 1'b1;
        idle(1);
        chk({7'h0, oe}, 8'h00);
        chk({7'h0, od}, 8'h00);
        for (int a = 0; a < 9; a++) rchk(a[7:0], 8'h00);
        t_periph();
        t_system();
        t_gpio();
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        tally_and_finish();
    end
endmodule : hwe_wake_aggregator_tb
`default_nettype wire
